// File: common/gdi_pkg.sv
// Shared constants, bus carriers and state encodings for the bus interface
package gdi_pkg;
  localparam int  DATA_W      = 8;
  localparam int  ERR_W       = 9;
  localparam int  FIFO_DEPTH  = 8;
  // Command bytes seen under attention, parity bit masked off
  localparam logic [7:0] CMD_MASK = 8'h7F;
  localparam logic [7:0] CMD_GTL  = 8'h01;
  localparam logic [7:0] CMD_SDC  = 8'h04;
  localparam logic [7:0] CMD_GET  = 8'h08;
  localparam logic [7:0] CMD_LLO  = 8'h11;
  localparam logic [7:0] CMD_DCL  = 8'h14;
  localparam logic [7:0] CMD_SPE  = 8'h18;
  localparam logic [7:0] CMD_SPD  = 8'h19;
  localparam logic [7:0] CMD_UNL  = 8'h3F;
  localparam logic [7:0] CMD_UNT  = 8'h5F;
  localparam logic [2:0] GRP_LISTEN = 3'h1;
  localparam logic [2:0] GRP_TALK   = 3'h2;
  localparam logic [2:0] GRP_SECOND = 3'h3;
  localparam logic [7:0] EXEC_CHAR   = 8'h58;
  localparam logic [7:0] EXEC_CHAR_L = 8'h78;
  // Address switches
  localparam logic [5:0] ADDR_DEFAULT = 6'h12;
  localparam logic [5:0] ADDR_STD_MAX = 6'h1E;
  localparam logic [5:0] ADDR_MST_MIN = 6'h1E;
  localparam logic [5:0] ADDR_MST_MAX = 6'h3C;
  localparam logic [5:0] ADDR_MST_OFS = 6'h1E;
  localparam logic [5:0] DIGIT_WEIGHT = 6'h0A;
  localparam int  RQS_BIT = 6;
  // Error status word bit positions
  localparam int  ERR_BAD_CMD = 0;
  localparam int  ERR_BAD_OPT = 1;
  localparam int  ERR_MS      = 2;
  localparam int  ERR_NOT_REM = 3;
  localparam int  ERR_EARLY   = 4;
  localparam int  ERR_OVERRUN = 5;
  localparam int  ERR_MEM     = 6;
  localparam int  ERR_CARD    = 7;
  localparam int  ERR_SETUP   = 8;
  localparam logic [ERR_W-1:0] ERR_NONE = 9'h000;

  // Bus lines in asserted-true form
  typedef struct packed {
    logic [7:0] dio;
    logic       dav;
    logic       nrfd;
    logic       ndac;
    logic       eoi;
    logic       atn;
    logic       ifc;
    logic       ren;
  } gdi_bus_in_s;

  typedef struct packed {
    logic [7:0] dio_o;
    logic [7:0] dio_oe;
    logic       dav_o;
    logic       dav_oe;
    logic       nrfd_o;
    logic       nrfd_oe;
    logic       ndac_o;
    logic       ndac_oe;
    logic       eoi_o;
    logic       eoi_oe;
    logic       srq_o;
    logic       srq_oe;
  } gdi_bus_out_s;

  typedef struct packed {
    logic bad_command_fault;
    logic bad_option_fault;
    logic ms_fault;
    logic mem_fault;
    logic card_id_fault;
    logic setup_fault;
  } gdi_fault_in_s;

  typedef enum logic [2:0] {
    ACC_IDLE = 3'b001,
    ACC_RDY  = 3'b010,
    ACC_WAIT = 3'b100
  } gdi_acc_e;

  typedef enum logic [2:0] {
    SRC_IDLE = 3'b001,
    SRC_SDYS = 3'b010,
    SRC_STRS = 3'b100
  } gdi_src_e;
endpackage : gdi_pkg

// File: logic/gdi_fifo.sv
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
module gdi_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             clk,
  input  wire logic             resetn,
  input  wire logic             flush,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wr_reg;
  logic [AW-1:0]    rd_reg;
  logic [AW:0]      cnt_reg;
  logic             push;
  logic             pop;

  assign in_ready  = (cnt_reg != (AW+1)'(DEPTH));
  assign out_valid = (cnt_reg != '0);
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  assign out_data  = mem_reg[rd_reg];

  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
    bump = (p == (AW)'(DEPTH-1)) ? '0 : p + 1'b1;
  endfunction : bump

  always_ff @(posedge clk) begin
    if (push) begin
      mem_reg[wr_reg] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wr_reg  <= '0;
      rd_reg  <= '0;
      cnt_reg <= '0;
    end else if (flush) begin
      wr_reg  <= '0;
      rd_reg  <= '0;
      cnt_reg <= '0;
    end else begin
      if (push) begin
        wr_reg <= bump(wr_reg);
      end
      if (pop) begin
        rd_reg <= bump(rd_reg);
      end
      cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : gdi_fifo

// File: logic/gdi_device.sv
// Device-side bus interface: handshakes, talker, listener, service request, errors
`timescale 1ns/1ps
module gdi_device #(
  parameter int DATA_W = gdi_pkg::DATA_W,
  parameter int DEPTH  = gdi_pkg::FIFO_DEPTH
) (
  input  wire logic                           clk,
  input  wire logic                           resetn,
  input  wire gdi_pkg::gdi_bus_in_s           bus_i,
  output gdi_pkg::gdi_bus_out_s               bus_o,
  input  wire logic [3:0]                     sw_tens,
  input  wire logic [3:0]                     sw_ones,
  input  wire logic                           unit_master,
  input  wire logic                           unit_slave,
  output logic [DATA_W-1:0]                   rx_data,
  output logic                                rx_valid,
  input  wire logic                           rx_ready,
  input  wire logic [DATA_W-1:0]              tx_data,
  input  wire logic                           tx_eoi,
  input  wire logic                           tx_valid,
  output logic                                tx_ready,
  input  wire logic [DATA_W-1:0]              status_byte,
  input  wire logic                           svc_request,
  input  wire logic                           srq_on_error,
  input  wire gdi_pkg::gdi_fault_in_s         fault_i,
  input  wire logic                           err_clear,
  input  wire logic                           trig_ready,
  input  wire logic                           matrix_ready,
  input  wire logic                           local_key,
  output logic                                talk_active,
  output logic                                listen_active,
  output logic                                remote,
  output logic                                lockout,
  output logic                                dev_clear,
  output logic                                trigger,
  output logic [gdi_pkg::ERR_W-1:0]           error_status_word,
  output logic                                fault_lamp,
  output logic                                addr_valid,
  output logic [4:0]                          my_addr
);
  gdi_pkg::gdi_acc_e    acc_reg;
  gdi_pkg::gdi_src_e    src_reg;
  logic                 addr_cap_reg;
  logic                 addr_ok_reg;
  logic [4:0]           addr_reg;
  logic                 talk_reg;
  logic                 listen_reg;
  logic                 spms_reg;
  logic                 rem_reg;
  logic                 llo_reg;
  logic                 discard_reg;
  logic                 srq_reg;
  logic                 clr_reg;
  logic                 trig_reg;
  logic [gdi_pkg::ERR_W-1:0] err_reg;
  logic [DATA_W-1:0]    dio_reg;
  logic                 eoi_reg;
  logic                 rqs_sent_reg;
  logic                 acc_take;
  logic [7:0]           cmd;
  logic                 is_cmd;
  logic                 is_data;
  logic                 is_exec;
  logic                 mla;
  logic                 mta;
  logic                 dcl_hit;
  logic                 get_hit;
  logic                 trig_ok;
  logic [gdi_pkg::ERR_W-1:0] err_set;
  logic                 fifo_in_ready;
  logic                 fifo_push;
  logic                 src_load;
  logic [6:0]           sw_val;

  function automatic logic [6:0] sw_decode(input logic [3:0] t, input logic [3:0] o);
    sw_decode = 7'(t) * 7'(gdi_pkg::DIGIT_WEIGHT) + {3'h0, o};
  endfunction : sw_decode
  // Addresses are caught once after reset so a changed switch needs a reset
  assign sw_val = sw_decode(sw_tens, sw_ones);
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      addr_cap_reg <= 1'b0;
      addr_ok_reg  <= 1'b0;
      addr_reg     <= gdi_pkg::ADDR_DEFAULT[4:0];
    end else if (!addr_cap_reg) begin
      addr_cap_reg <= 1'b1;
      if (unit_slave) begin
        addr_ok_reg <= 1'b0;
      end else if (unit_master) begin
        addr_ok_reg <= (sw_val >= gdi_pkg::ADDR_MST_MIN) &&
                       (sw_val <= gdi_pkg::ADDR_MST_MAX);
        addr_reg    <= 5'(sw_val - gdi_pkg::ADDR_MST_OFS);
      end else begin
        addr_ok_reg <= (sw_val <= gdi_pkg::ADDR_STD_MAX);
        addr_reg    <= sw_val[4:0];
      end
    end
  end
  // Byte decode at the moment the acceptor takes it
  assign acc_take = (acc_reg == gdi_pkg::ACC_RDY) && bus_i.dav &&
                    (bus_i.atn || fifo_in_ready || discard_reg || !listen_reg);
  assign cmd      = bus_i.dio & gdi_pkg::CMD_MASK;
  assign is_cmd   = acc_take && bus_i.atn && addr_cap_reg;
  assign is_data  = acc_take && !bus_i.atn && listen_reg;
  assign is_exec  = (bus_i.dio == gdi_pkg::EXEC_CHAR) || (bus_i.dio == gdi_pkg::EXEC_CHAR_L);
  // Secondary group falls through every compare below and is ignored
  assign mla      = is_cmd && addr_ok_reg && (cmd[7:5] == gdi_pkg::GRP_LISTEN) &&
                    (cmd[4:0] == addr_reg) && (cmd != gdi_pkg::CMD_UNL);
  assign mta      = is_cmd && addr_ok_reg && (cmd[7:5] == gdi_pkg::GRP_TALK) &&
                    (cmd[4:0] == addr_reg) && (cmd != gdi_pkg::CMD_UNT);
  assign dcl_hit  = is_cmd && ((cmd == gdi_pkg::CMD_DCL) ||
                    (listen_reg && cmd == gdi_pkg::CMD_SDC));
  assign get_hit  = is_cmd && listen_reg && (cmd == gdi_pkg::CMD_GET);
  assign trig_ok  = get_hit && trig_ready;
  // Acceptor handshake; NRFD held in the ready state while the receive buffer is full and ATN is false
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      acc_reg <= gdi_pkg::ACC_IDLE;
    end else begin
      case (acc_reg)
        gdi_pkg::ACC_IDLE: begin
          if (bus_i.atn || listen_reg) begin
            acc_reg <= gdi_pkg::ACC_RDY;
          end
        end
        gdi_pkg::ACC_RDY: begin
          if (bus_i.ifc || !(bus_i.atn || listen_reg)) begin
            acc_reg <= gdi_pkg::ACC_IDLE;
          end else if (acc_take) begin
            acc_reg <= gdi_pkg::ACC_WAIT;
          end
        end
        gdi_pkg::ACC_WAIT: begin
          if (!bus_i.dav) begin
            acc_reg <= gdi_pkg::ACC_IDLE;
          end
        end
        default: acc_reg <= gdi_pkg::ACC_IDLE;
      endcase
    end
  end
  // Talker and listener addressing
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      talk_reg   <= 1'b0;
      listen_reg <= 1'b0;
      spms_reg   <= 1'b0;
    end else if (bus_i.ifc) begin
      talk_reg   <= 1'b0;
      listen_reg <= 1'b0;
      spms_reg   <= 1'b0;
    end else if (is_cmd) begin
      if (mta) begin
        talk_reg   <= 1'b1;
        listen_reg <= 1'b0;
      end else if (cmd == gdi_pkg::CMD_UNT || (is_cmd && cmd[7:5] == gdi_pkg::GRP_TALK)) begin
        talk_reg <= 1'b0;
      end
      if (mla) begin
        listen_reg <= 1'b1;
        talk_reg   <= 1'b0;
      end else if (cmd == gdi_pkg::CMD_UNL) begin
        listen_reg <= 1'b0;
      end
      if (cmd == gdi_pkg::CMD_SPE) begin
        spms_reg <= 1'b1;
      end else if (cmd == gdi_pkg::CMD_SPD) begin
        spms_reg <= 1'b0;
      end
    end
  end
  // Remote/local; remote needs REN plus own listen address
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rem_reg <= 1'b0;
      llo_reg <= 1'b0;
    end else if (!bus_i.ren) begin
      rem_reg <= 1'b0;
      llo_reg <= 1'b0;
    end else begin
      if (mla) begin
        rem_reg <= 1'b1;
      end else if ((is_cmd && listen_reg && cmd == gdi_pkg::CMD_GTL) ||
                   (local_key && !llo_reg) || bus_i.ifc) begin
        rem_reg <= 1'b0;
      end
      if (is_cmd && cmd == gdi_pkg::CMD_LLO) begin
        llo_reg <= 1'b1;
      end
    end
  end

  // Error sources; hardware set wins over the software clear
  always_comb begin
    err_set                        = gdi_pkg::ERR_NONE;
    err_set[gdi_pkg::ERR_BAD_CMD]  = fault_i.bad_command_fault;
    err_set[gdi_pkg::ERR_BAD_OPT]  = fault_i.bad_option_fault;
    err_set[gdi_pkg::ERR_MS]       = fault_i.ms_fault;
    err_set[gdi_pkg::ERR_MEM]      = fault_i.mem_fault;
    err_set[gdi_pkg::ERR_CARD]     = fault_i.card_id_fault;
    err_set[gdi_pkg::ERR_SETUP]    = fault_i.setup_fault;
    err_set[gdi_pkg::ERR_NOT_REM]  = is_data && is_exec && !rem_reg;
    err_set[gdi_pkg::ERR_OVERRUN]  = get_hit && !trig_ready;
    err_set[gdi_pkg::ERR_EARLY]    = trig_ok && !matrix_ready;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      err_reg <= gdi_pkg::ERR_NONE;
    end else begin
      err_reg <= ((err_clear || dcl_hit) ? gdi_pkg::ERR_NONE : err_reg) | err_set;
    end
  end

  // Discard data after a bad command, through the next execute char
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      discard_reg <= 1'b0;
    end else if (fault_i.bad_command_fault || fault_i.bad_option_fault) begin
      discard_reg <= 1'b1;
    end else if (dcl_hit || (is_data && is_exec)) begin
      discard_reg <= 1'b0;
    end
  end

  // Service request: user request or error when enabled
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      srq_reg <= 1'b0;
    end else if (svc_request || (srq_on_error && (err_set != gdi_pkg::ERR_NONE))) begin
      srq_reg <= 1'b1;
    end else if (dcl_hit || (rqs_sent_reg && src_reg == gdi_pkg::SRC_STRS && !bus_i.ndac)) begin
      srq_reg <= 1'b0;
    end
  end

  // Device clear and trigger pulses
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      clr_reg  <= 1'b0;
      trig_reg <= 1'b0;
    end else begin
      clr_reg  <= dcl_hit;
      trig_reg <= trig_ok;
    end
  end

  // Source handshake; a status byte replaces user data in serial poll mode
  assign src_load = (src_reg == gdi_pkg::SRC_IDLE) && talk_reg && !bus_i.atn &&
                    (spms_reg || tx_valid);
  assign tx_ready = (src_reg == gdi_pkg::SRC_IDLE) && talk_reg && !bus_i.atn && !spms_reg;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      src_reg      <= gdi_pkg::SRC_IDLE;
      dio_reg      <= '0;
      eoi_reg      <= 1'b0;
      rqs_sent_reg <= 1'b0;
    end else if (bus_i.atn || !talk_reg || bus_i.ifc) begin
      src_reg <= gdi_pkg::SRC_IDLE;
      eoi_reg <= 1'b0;
    end else begin
      case (src_reg)
        gdi_pkg::SRC_IDLE: begin
          if (src_load) begin
            src_reg <= gdi_pkg::SRC_SDYS;
            if (spms_reg) begin
              dio_reg          <= status_byte;
              dio_reg[gdi_pkg::RQS_BIT] <= srq_reg;
              rqs_sent_reg     <= srq_reg;
              eoi_reg          <= 1'b0;
            end else begin
              dio_reg      <= tx_data;
              rqs_sent_reg <= 1'b0;
              eoi_reg      <= tx_eoi;
            end
          end
        end
        gdi_pkg::SRC_SDYS: begin
          if (!bus_i.nrfd) begin
            src_reg <= gdi_pkg::SRC_STRS;
          end
        end
        gdi_pkg::SRC_STRS: begin
          if (!bus_i.ndac) begin
            src_reg <= gdi_pkg::SRC_IDLE;
            eoi_reg <= 1'b0;
          end
        end
        default: src_reg <= gdi_pkg::SRC_IDLE;
      endcase
    end
  end

  // Receive buffer toward the command parser
  assign fifo_push = is_data && !discard_reg;
  gdi_fifo #(
    .WIDTH (DATA_W),
    .DEPTH (DEPTH)
  ) u_rx_fifo (
    .clk       (clk),
    .resetn    (resetn),
    .flush     (dcl_hit),
    .in_data   (bus_i.dio),
    .in_valid  (fifo_push),
    .in_ready  (fifo_in_ready),
    .out_data  (rx_data),
    .out_valid (rx_valid),
    .out_ready (rx_ready)
  );

  // Open-collector drives; no IFC, REN, ATN or parallel poll output exists
  always_comb begin
    bus_o         = '0;
    bus_o.dio_o   = dio_reg;
    bus_o.dio_oe  = (src_reg != gdi_pkg::SRC_IDLE) ? dio_reg : 8'h00;
    bus_o.dav_o   = 1'b1;
    bus_o.dav_oe  = (src_reg == gdi_pkg::SRC_STRS);
    bus_o.eoi_o   = 1'b1;
    bus_o.eoi_oe  = (src_reg != gdi_pkg::SRC_IDLE) && eoi_reg;
    bus_o.nrfd_o  = 1'b1;
    bus_o.nrfd_oe = (acc_reg == gdi_pkg::ACC_WAIT) ||
                    ((acc_reg == gdi_pkg::ACC_RDY) && !bus_i.atn && !fifo_in_ready);
    bus_o.ndac_o  = 1'b1;
    bus_o.ndac_oe = (acc_reg == gdi_pkg::ACC_RDY);
    bus_o.srq_o   = 1'b1;
    bus_o.srq_oe  = srq_reg;
  end

  assign talk_active       = talk_reg;
  assign listen_active     = listen_reg;
  assign remote            = rem_reg;
  assign lockout           = llo_reg;
  assign dev_clear         = clr_reg;
  assign trigger           = trig_reg;
  assign error_status_word = err_reg;
  assign fault_lamp        = (err_reg != gdi_pkg::ERR_NONE);
  assign addr_valid        = addr_ok_reg;
  assign my_addr           = addr_reg;
endmodule : gdi_device

// File: tb/gdi_ctl_model.sv
// Bus controller model: sends commands and data, accepts talker bytes
`timescale 1ns/1ps
module gdi_ctl_model (
  input  wire logic                  clk,
  input  wire gdi_pkg::gdi_bus_out_s bus_o,
  output gdi_pkg::gdi_bus_in_s       bus_i
);
  // Released lines read false through the bus pull-ups
  initial bus_i = '0;

  task automatic tick(inout int n);
    @(posedge clk);
    #1;
    n++;
  endtask : tick

  task automatic ren_set(input logic v);
    bus_i.ren = v;
  endtask : ren_set

  task automatic put(input logic [7:0] b, input logic atn);
    int n;
    n = 0;
    bus_i.atn = atn;
    // One edge under the new ATN level before the handshake lines move
    tick(n);
    bus_i.nrfd = 1'b0;
    bus_i.ndac = 1'b0;
    while (!(bus_o.ndac_oe && !bus_o.nrfd_oe) && n < 99) tick(n);
    bus_i.dio = b;
    bus_i.dav = 1'b1;
    while (bus_o.ndac_oe && n < 199) tick(n);
    bus_i.dav = 1'b0;
    bus_i.dio = 8'h00;
    tick(n);
  endtask : put

  task automatic get(output logic [8:0] v);
    int n;
    n = 0;
    bus_i.atn = 1'b0;
    bus_i.ndac = 1'b1;
    bus_i.nrfd = 1'b0;
    while (!bus_o.dav_oe && n < 99) tick(n);
    v = {bus_o.eoi_oe, bus_o.dio_o & bus_o.dio_oe};
    bus_i.nrfd = 1'b1;
    bus_i.ndac = 1'b0;
    while (bus_o.dav_oe && n < 199) tick(n);
    // Hold off the next byte until asked again
    bus_i.ndac = 1'b1;
  endtask : get
endmodule : gdi_ctl_model

// File: tb/gdi_device_asserts.sv
// Port-level checks for the device bus interface
`timescale 1ns/1ps
module gdi_device_asserts #(
  parameter int DATA_W = gdi_pkg::DATA_W,
  parameter int DEPTH  = gdi_pkg::FIFO_DEPTH
) (
  input wire logic                         clk,
  input wire logic                         resetn,
  input wire gdi_pkg::gdi_bus_in_s         bus_i,
  input wire gdi_pkg::gdi_bus_out_s        bus_o,
  input wire logic                         svc_request,
  input wire gdi_pkg::gdi_fault_in_s       fault_i,
  input wire logic                         trig_ready,
  input wire logic                         talk_active,
  input wire logic                         listen_active,
  input wire logic                         trigger,
  input wire logic [gdi_pkg::ERR_W-1:0]    error_status_word,
  input wire logic                         addr_valid,
  input wire logic [4:0]                   my_addr
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);

  a_talk_idle: assert property (
    !talk_active && !$past(talk_active) |-> bus_o.dio_oe == 8'h00 && !bus_o.dav_oe)
    else $error("bus driven while not talker");
  a_atn_quiet: assert property (
    bus_i.atn && $past(bus_i.atn) |-> bus_o.dio_oe == 8'h00 && !bus_o.dav_oe)
    else $error("data lines driven under attention");
  a_one_role: assert property (
    !(talk_active && listen_active))
    else $error("talker and listener together");
  a_srq_req: assert property (
    svc_request |=> bus_o.srq_oe)
    else $error("service request not raised");
  a_mem_err: assert property (
    fault_i.mem_fault |=> error_status_word[gdi_pkg::ERR_MEM])
    else $error("memory fault not recorded");
  a_trig_cause: assert property (
    trigger |-> $past(trig_ready) && $past(listen_active))
    else $error("trigger without cause");
  a_addr_hold: assert property (
    addr_valid && $past(addr_valid) |-> $stable(my_addr))
    else $error("address changed after capture");
  a_cmd_take: assert property (
    bus_o.ndac_oe && bus_i.dav && bus_i.atn |=> bus_o.nrfd_oe && !bus_o.ndac_oe)
    else $error("command byte not taken");

  c_trig: cover property (trigger);
  c_src: cover property (bus_o.dav_oe);
  c_srq: cover property (bus_o.srq_oe);
endmodule : gdi_device_asserts

bind gdi_device gdi_device_asserts #(.DATA_W(DATA_W), .DEPTH(DEPTH)) u_chk (
  .clk, .resetn, .bus_i, .bus_o, .svc_request, .fault_i, .trig_ready, .talk_active,
  .listen_active, .trigger, .error_status_word, .addr_valid, .my_addr
);

// File: tb/tb_top.sv
// Self-checking bench for the device bus interface
`timescale 1ns/1ps
module tb_top;
  logic clk, resetn, unit_master, unit_slave, rx_ready, tx_eoi, tx_valid, tx_take;
  logic svc_request, srq_on_error, err_clear, trig_ready, matrix_ready, local_key;
  logic rx_valid, tx_ready, talk_active, listen_active, remote, lockout;
  logic dev_clear, trigger, fault_lamp, addr_valid, trig_seen, clr_seen;
  logic [3:0] sw_tens, sw_ones;
  logic [7:0] rx_data, tx_data, status_byte;
  logic [4:0] my_addr;
  logic [8:0] error_status_word, got;
  gdi_pkg::gdi_bus_in_s   bus_i;
  gdi_pkg::gdi_bus_out_s  bus_o;
  gdi_pkg::gdi_fault_in_s fault_i;
  int fails, num_checks;

  gdi_device uut (.clk, .resetn, .bus_i, .bus_o, .sw_tens, .sw_ones, .unit_master,
    .unit_slave, .rx_data, .rx_valid, .rx_ready, .tx_data, .tx_eoi, .tx_valid, .tx_ready,
    .status_byte, .svc_request, .srq_on_error, .fault_i, .err_clear, .trig_ready,
    .matrix_ready, .local_key, .talk_active, .listen_active, .remote, .lockout,
    .dev_clear, .trigger, .error_status_word, .fault_lamp, .addr_valid, .my_addr);
  gdi_ctl_model ctl (.clk, .bus_o, .bus_i);

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Pulses last one cycle, so latch them for the scenarios
  always @(posedge clk) if (trigger) trig_seen = 1'b1;
  always @(posedge clk) if (dev_clear) clr_seen = 1'b1;
  always @(negedge clk) tx_take = tx_valid && tx_ready;
  always @(posedge clk) if (tx_take) tx_valid <= 1'b0;

  task automatic complete_run();
    if (fails == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : complete_run

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step

  task automatic pulse(ref logic s);
    s = 1'b1;
    step(1);
    s = 1'b0;
  endtask : pulse

  task automatic pop(input logic [7:0] e);
    int n;
    for (n = 0; n < 20 && !rx_valid; n++) step(1);
    chk(rx_data, e);
    pulse(rx_ready);
  endtask : pop

  task automatic t_addr();
    // {tens, ones, master, slave, valid, address}
    logic [15:0] tb [11] = '{16'h3100, 16'h2980, 16'h1840, 16'h60BE, 16'h0020,
                            16'h303E, 16'h30A0, 16'h48B2, 16'h7000, 16'h9980, 16'h1832};
    foreach (tb[i]) begin
      resetn = 1'b0;
      {sw_tens, sw_ones, unit_master, unit_slave} = tb[i][15:6];
      step(2);
      resetn = 1'b1;
      step(2);
      chk(addr_valid, tb[i][5]);
      if (tb[i][5]) chk(my_addr, tb[i][4:0]);
    end
    sw_ones = 4'h3;
    step(3);
    chk(my_addr, 5'h12);
    sw_ones = 4'h8;
  endtask : t_addr

  task automatic t_listen_fifo();
    ctl.ren_set(1'b1);
    ctl.put(8'h32, 1'b1);
    chk({listen_active, remote, talk_active}, 3'b110);
    ctl.put(8'h72, 1'b1);
    chk(listen_active, 1'b1);
    for (int i = 0; i < 8; i++) ctl.put(8'(8'hC0 + i), 1'b0);
    step(2);
    chk(bus_o.nrfd_oe, 1'b1);
    for (int i = 0; i < 8; i++) pop(8'(8'hC0 + i));
    chk(rx_valid, 1'b0);
  endtask : t_listen_fifo

  task automatic t_talk_poll();
    ctl.put(8'h52, 1'b1);
    chk({talk_active, listen_active}, 2'b10);
    tx_data = 8'hA5;
    tx_eoi = 1'b1;
    tx_valid = 1'b1;
    ctl.get(got);
    chk({got, tx_ready}, 10'h34B);
    tx_eoi = 1'b0;
    status_byte = 8'h05;
    pulse(svc_request);
    chk(bus_o.srq_oe, 1'b1);
    ctl.put(8'h18, 1'b1);
    ctl.put(8'h52, 1'b1);
    ctl.get(got);
    chk({got, bus_o.srq_oe}, 10'h08A);
    ctl.get(got);
    chk(got, 9'h005);
    ctl.put(8'h19, 1'b1);
    ctl.put(8'h32, 1'b1);
    chk({talk_active, listen_active}, 2'b01);
  endtask : t_talk_poll

  task automatic t_remote();
    ctl.put(8'h11, 1'b1);
    pulse(local_key);
    chk({remote, lockout}, 2'b11);
    ctl.put(8'h01, 1'b1);
    chk(remote, 1'b0);
    ctl.put(8'h58, 1'b0);
    chk({error_status_word[3], fault_lamp}, 2'b11);
    pop(8'h58);
    ctl.ren_set(1'b0);
    step(2);
    chk(lockout, 1'b0);
    ctl.ren_set(1'b1);
    ctl.put(8'h32, 1'b1);
    pulse(err_clear);
    chk({remote, error_status_word}, 10'h200);
  endtask : t_remote

  task automatic t_trig();
    // {ready, matrix ready, trigger seen, overrun, early}
    logic [4:0] tt [3] = '{5'b01010, 5'b10101, 5'b11100};
    foreach (tt[i]) begin
      {trig_ready, matrix_ready} = tt[i][4:3];
      trig_seen = 1'b0;
      ctl.put(8'h08, 1'b1);
      step(2);
      chk({trig_seen, error_status_word[5:4]}, tt[i][2:0]);
      pulse(err_clear);
    end
  endtask : t_trig

  task automatic t_clear();
    int pos [6] = '{0, 1, 2, 6, 7, 8};
    logic [7:0] cmd [2] = '{8'h14, 8'h04};
    srq_on_error = 1'b1;
    foreach (pos[i]) begin
      fault_i = 6'(6'h20 >> i);
      step(1);
      fault_i = '0;
      chk(error_status_word[pos[i]], 1'b1);
    end
    chk({bus_o.srq_oe, fault_lamp}, 2'b11);
    foreach (cmd[i]) begin
      fault_i.setup_fault = 1'b1;
      step(1);
      fault_i = '0;
      clr_seen = 1'b0;
      ctl.put(cmd[i], 1'b1);
      step(2);
      chk({clr_seen, error_status_word, bus_o.srq_oe}, 11'h400);
    end
    srq_on_error = 1'b0;
  endtask : t_clear

  task automatic t_discard();
    fault_i.bad_command_fault = 1'b1;
    step(1);
    fault_i = '0;
    ctl.put(8'h41, 1'b0);
    ctl.put(8'h58, 1'b0);
    ctl.put(8'h42, 1'b0);
    pop(8'h42);
    chk({rx_valid, error_status_word[0]}, 2'b01);
  endtask : t_discard

  initial begin
    resetn = 1'b0;
    {unit_master, unit_slave, rx_ready, tx_eoi, tx_valid, svc_request} = '0;
    {srq_on_error, err_clear, trig_ready, matrix_ready, local_key} = '0;
    {sw_tens, sw_ones, tx_data, status_byte, fault_i, trig_seen, clr_seen} = '0;
    fails = 0;
    num_checks = 0;
    #5;
    t_addr();
    t_listen_fifo();
    t_talk_poll();
    t_remote();
    t_trig();
    t_clear();
    t_discard();
    complete_run();
  end

  // Whole sequence needs well under ten thousand cycles
  initial begin
    #2000000;
    fails++;
    complete_run();
  end
endmodule : tb_top
